// ==== shared/sspi_cfg.svh ====
// constants of the serial peripheral port: register indices, fields, reset values
`ifndef SSPI_CFG_SVH
`define SSPI_CFG_SVH

// ==========================================================
// register indices (byte address = index * 4)
`define SSPI_IX_IRQ_FLAGS1  8'h0c
`define SSPI_IX_DATA_BUF    8'h13
`define SSPI_IX_PORT_CTRL   8'h14
`define SSPI_IX_DIR_A       8'h85
`define SSPI_IX_DIR_C       8'h87
`define SSPI_IX_IRQ_ENS1    8'h8c
`define SSPI_IX_PORT_STATE  8'h94
`define SSPI_IX_IRQ_STATUS  8'ha0
`define SSPI_IX_IRQ_CLEAR   8'ha1
`define SSPI_IX_IRQ_ENABLE  8'ha2

// ==========================================================
// control, port state, flag and direction bit fields
`define SSPI_CTL_WCOL       7
`define SSPI_CTL_OVF        6
`define SSPI_CTL_EN         5
`define SSPI_CTL_POL        4
`define SSPI_STA_SAMP       7
`define SSPI_STA_EDGE       6
`define SSPI_STA_FULL       0
`define SSPI_FLAG_BIT       3
`define SSPI_DIR_SCK        3
`define SSPI_DIR_SOUT       5

// ==========================================================
// mode_select_field encodings
`define SSPI_M_DIV4         4'h0
`define SSPI_M_DIV16        4'h1
`define SSPI_M_DIV64        4'h2
`define SSPI_M_TMR          4'h3
`define SSPI_M_SS           4'h4
`define SSPI_M_NOSS         4'h5

// ==========================================================
// oscillator divisions, reset values, frame length
`define SSPI_FOSC_DIV4      4
`define SSPI_FOSC_DIV16     16
`define SSPI_FOSC_DIV64     64
`define SSPI_DIR_C_RST      8'hff
`define SSPI_DIR_A_RST      6'h3f
`define SSPI_BITS           4'h8

`endif

// ==== shared/sspi_pkg.sv ====
// types of the serial peripheral port
package sspi_pkg;

	typedef enum logic [1:0] {
		SSPI_IDLE  = 2'b00,
		SSPI_LEAD  = 2'b01,
		SSPI_TRAIL = 2'b10
	} sspi_st_t;

	typedef struct packed {
		logic [7:0]  ctrl;
		logic        samp_late;
		logic        edge_sel;
		logic        full;
		logic [7:0]  dbuf;
		logic [7:0]  sr;
		logic [3:0]  bitcnt;
		sspi_st_t    st;
		logic [5:0]  div;
		logic [7:0]  dir_c;
		logic [5:0]  dir_a;
		logic [7:0]  irq_ens1;
		logic [1:0]  irq_en;
		logic [1:0]  irq_st;
		logic        wr_pend;
		logic [7:0]  wr_idx;
		logic [2:0]  sck_s;
		logic [2:0]  sin_s;
		logic [2:0]  ss_s;
		logic        sck_f;
		logic        sin_f;
		logic        ss_f;
		logic        sck_o;
		logic        sck_oe;
		logic        sout_o;
		logic        sout_oe;
		logic        irq;
		logic [31:0] hrdata;
		logic        hreadyout;
	} sspi_state_t;

endpackage

// ==== hw/sspi_top.sv ====
// serial peripheral port in spi mode with an ahb-lite register slave
//
// Contract
// - modes 1,2 master at osc/16, osc/64
// - mode 3 master at timer two/2
// - mode 4 slave, select pin in control
// - mode 5 slave, select pin ignored
// - port works only while enable set
// - mode 4 select high resets transfer logic
// - out direction bit reads output enable
// - direction rewrite with select high disables out
// - mode 0 master at osc/4
// - polarity bit sets idle clock level
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "sspi_cfg.svh"

module sspi_top import sspi_pkg::*; (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        timer_two_tick,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin_o,
	output logic             serial_out_pin_oe,
	input  wire logic        ss_n_i,
	output logic             irq
);

	localparam logic [5:0] HALF4  = 6'(`SSPI_FOSC_DIV4 / 2 - 1);
	localparam logic [5:0] HALF16 = 6'(`SSPI_FOSC_DIV16 / 2 - 1);
	localparam logic [5:0] HALF64 = 6'(`SSPI_FOSC_DIV64 / 2 - 1);
	// select idles high, so leaving reset must not look like a select
	localparam sspi_state_t RST = '{dir_c: `SSPI_DIR_C_RST, dir_a: `SSPI_DIR_A_RST,
		ss_s: 3'h7, ss_f: 1'h1,
		hreadyout: 1'b1, st: SSPI_IDLE, default: '0};

	sspi_state_t r;
	sspi_state_t n;
	logic [3:0]  md;
	logic        en, pol, master, slave, spi_on, ss_gate;
	logic        tick, lead_ev, trail_ev, samp, chg, done;
	logic        acc, mapped;
	logic [7:0]  idx, rd;
	logic [5:0]  half;
	logic [3:0]  cnt_after;

	// change is accepted only once stages two and three agree
	function automatic logic filt(input logic [2:0] s, input logic f);
		filt = (s[1] == s[2]) ? s[1] : f;
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		n = r;
		n.sck_s = {r.sck_s[1:0], sck_i};
		n.sin_s = {r.sin_s[1:0], serial_in_pin};
		n.ss_s = {r.ss_s[1:0], ss_n_i};
		n.sck_f = filt(r.sck_s, r.sck_f);
		n.sin_f = filt(r.sin_s, r.sin_f);
		n.ss_f = filt(r.ss_s, r.ss_f);

		md = r.ctrl[3:0];
		en = r.ctrl[`SSPI_CTL_EN];
		pol = r.ctrl[`SSPI_CTL_POL];
		master = en && (md <= `SSPI_M_TMR);
		slave = en && (md == `SSPI_M_SS || md == `SSPI_M_NOSS);
		spi_on = master || slave;
		ss_gate = (md == `SSPI_M_SS) && r.ss_f;

		case (md)
			`SSPI_M_DIV4: half = HALF4;
			`SSPI_M_DIV16: half = HALF16;
			default: half = HALF64;
		endcase
		if (master && r.st != SSPI_IDLE) begin
			n.div = (r.div == half) ? 6'h0 : r.div + 6'h1;
			tick = (md == `SSPI_M_TMR) ? timer_two_tick : (r.div == half);
		end else begin
			n.div = 6'h0;
			tick = 1'b0;
		end

		if (master) begin
			lead_ev = tick && r.st == SSPI_LEAD;
			trail_ev = tick && r.st == SSPI_TRAIL;
		end else begin
			lead_ev = slave && !ss_gate && n.sck_f != r.sck_f && n.sck_f != pol;
			trail_ev = slave && !ss_gate && n.sck_f != r.sck_f && n.sck_f == pol;
		end
		samp = r.edge_sel ? trail_ev : lead_ev;
		chg = r.edge_sel ? lead_ev : trail_ev;
		cnt_after = samp ? r.bitcnt + 4'h1 : r.bitcnt;
		done = trail_ev && cnt_after == `SSPI_BITS;

		// ==========================================================
		// bus: address phase answers reads at once, writes land next cycle
		acc = hsel && htrans[1] && hready;
		mapped = haddr[31:10] == 22'h0;
		idx = mapped ? haddr[9:2] : 8'h0;
		case (idx)
			`SSPI_IX_IRQ_FLAGS1: rd = {4'h0, r.irq_st[0], 3'h0};
			`SSPI_IX_DATA_BUF: rd = r.dbuf;
			`SSPI_IX_PORT_CTRL: rd = r.ctrl;
			`SSPI_IX_DIR_A: rd = {2'b00, r.dir_a};
			`SSPI_IX_DIR_C: begin
				rd = r.dir_c;
				// bit reads the output enable, so a rewrite copies it back
				if (en && ss_gate)
					rd[`SSPI_DIR_SOUT] = 1'b1;
			end
			`SSPI_IX_IRQ_ENS1: rd = r.irq_ens1;
			`SSPI_IX_PORT_STATE: rd = {r.samp_late, r.edge_sel, 5'h0, r.full};
			`SSPI_IX_IRQ_STATUS: rd = {6'h0, r.irq_st};
			`SSPI_IX_IRQ_ENABLE: rd = {6'h0, r.irq_en};
			default: rd = 8'h0;
		endcase
		n.wr_pend = acc && hwrite;
		n.wr_idx = idx;
		if (acc && !hwrite) begin
			n.hrdata = {24'h0, rd};
			if (idx == `SSPI_IX_DATA_BUF)
				n.full = 1'b0;
		end

		if (r.wr_pend) begin
			case (r.wr_idx)
				`SSPI_IX_PORT_CTRL: n.ctrl = hwdata[7:0];
				`SSPI_IX_PORT_STATE: begin
					n.samp_late = hwdata[`SSPI_STA_SAMP];
					n.edge_sel = hwdata[`SSPI_STA_EDGE];
				end
				`SSPI_IX_DATA_BUF: begin
					if (master ? r.st != SSPI_IDLE : (r.bitcnt != 4'h0 && !ss_gate))
						n.ctrl[`SSPI_CTL_WCOL] = 1'b1;
					else if (spi_on) begin
						n.sr = hwdata[7:0];
						n.sout_o = hwdata[7];
						if (master)
							n.st = SSPI_LEAD;
					end
				end
				`SSPI_IX_DIR_C: n.dir_c = hwdata[7:0];
				`SSPI_IX_DIR_A: n.dir_a = hwdata[5:0];
				`SSPI_IX_IRQ_FLAGS1:
					if (!hwdata[`SSPI_FLAG_BIT])
						n.irq_st[0] = 1'b0;
				`SSPI_IX_IRQ_ENS1: n.irq_ens1 = hwdata[7:0];
				`SSPI_IX_IRQ_CLEAR: n.irq_st = r.irq_st & ~hwdata[1:0];
				`SSPI_IX_IRQ_ENABLE: n.irq_en = hwdata[1:0];
				default: ;
			endcase
		end

		// ==========================================================
		// shifter; events follow the bus so a set beats a clear
		if (samp) begin
			// own clock launches the reply; a three-stage lag would cost a bit at osc/4
			n.sr = {r.sr[6:0], master ? serial_in_pin : r.sin_f};
			n.bitcnt = cnt_after;
		end
		if (chg)
			n.sout_o = r.sr[7];
		if (master) begin
			if (lead_ev) begin
				n.st = SSPI_TRAIL;
				n.sck_o = ~pol;
			end else if (trail_ev) begin
				n.st = done ? SSPI_IDLE : SSPI_LEAD;
				n.sck_o = pol;
			end else if (r.st == SSPI_IDLE)
				n.sck_o = pol;
		end
		if (done) begin
			n.bitcnt = 4'h0;
			if (r.full)
				n.ctrl[`SSPI_CTL_OVF] = 1'b1;
			else begin
				n.dbuf = n.sr;
				n.full = 1'b1;
			end
			n.irq_st[0] = 1'b1;
		end
		if (r.wr_pend && r.wr_idx == `SSPI_IX_DATA_BUF && n.ctrl[`SSPI_CTL_WCOL]
			&& !r.ctrl[`SSPI_CTL_WCOL])
			n.irq_st[1] = 1'b1;
		if (done && r.full)
			n.irq_st[1] = 1'b1;
		if (!spi_on) begin
			n.st = SSPI_IDLE;
			n.bitcnt = 4'h0;
		end
		if (slave && ss_gate)
			n.bitcnt = 4'h0;

		n.sck_oe = master && !r.dir_c[`SSPI_DIR_SCK];
		n.sout_oe = spi_on && !r.dir_c[`SSPI_DIR_SOUT] && !ss_gate;
		n.irq = |(n.irq_st & {r.irq_en[1], r.irq_en[0] | r.irq_ens1[`SSPI_FLAG_BIT]});
		n.hreadyout = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			r <= RST;
		else
			r <= n;
	end

	assign hrdata = r.hrdata;
	assign hreadyout = r.hreadyout;
	assign hresp = 1'b0;
	assign sck_o = r.sck_o;
	assign sck_oe = r.sck_oe;
	assign serial_out_pin_o = r.sout_o;
	assign serial_out_pin_oe = r.sout_oe;
	assign irq = r.irq;

	// ==========================================================
	// checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_div4;
		(master && md == `SSPI_M_DIV4 && r.st != SSPI_IDLE && tick) |=> !tick;
	endproperty
	a_div4: assert property (p_div4) else $error("osc/4 half period wrong");

	property p_div16;
		(master && md == `SSPI_M_DIV16 && tick) |=> (!tick)[*7];
	endproperty
	a_div16: assert property (p_div16) else $error("osc/16 half period wrong");

	property p_tmr;
		(master && md == `SSPI_M_TMR && r.st != SSPI_IDLE && timer_two_tick)
			|=> r.sck_o != $past(r.sck_o);
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer clock not followed");

	property p_ss_reset;
		(slave && md == `SSPI_M_SS && r.ss_f) |=> r.bitcnt == 4'h0 && !r.sout_oe;
	endproperty
	a_ss_reset: assert property (p_ss_reset) else $error("select high kept state");

	property p_noss;
		(slave && md == `SSPI_M_NOSS && !r.dir_c[`SSPI_DIR_SOUT]) |=> r.sout_oe;
	endproperty
	a_noss: assert property (p_noss) else $error("select wrongly gates out");

	property p_off;
		(!spi_on) |=> !r.sck_oe && !r.sout_oe && r.st == SSPI_IDLE;
	endproperty
	a_off: assert property (p_off) else $error("pins driven while off");

	property p_idle_pol;
		(master && r.st == SSPI_IDLE && !(r.wr_pend && r.wr_idx == `SSPI_IX_DATA_BUF))
			|=> r.sck_o == $past(pol);
	endproperty
	a_idle_pol: assert property (p_idle_pol) else $error("idle clock level wrong");

	property p_done;
		done |=> r.irq_st[0] && (r.full || r.ctrl[`SSPI_CTL_OVF]);
	endproperty
	a_done: assert property (p_done) else $error("byte end not flagged");

	property p_dir_read;
		(acc && !hwrite && idx == `SSPI_IX_DIR_C && en && ss_gate) |=> r.hrdata[5];
	endproperty
	a_dir_read: assert property (p_dir_read) else $error("direction readback wrong");

	property p_dir_off;
		r.dir_c[`SSPI_DIR_SOUT] |=> !r.sout_oe;
	endproperty
	a_dir_off: assert property (p_dir_off) else $error("out driven while disabled");

	property p_div64;
		(master && md == `SSPI_M_DIV64 && tick)
			|=> (!tick)[*8] ##1 (!tick)[*8] ##1 (!tick)[*8] ##1 (!tick)[*7];
	endproperty
	a_div64: assert property (p_div64) else $error("osc/64 half period wrong");

	property p_reserved;
		(r.ctrl[`SSPI_CTL_EN] && md > `SSPI_M_NOSS) |=> !r.sck_oe && !r.sout_oe;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved mode drives pins");

	property p_shift_in;
		(master && samp) |=> r.sr[0] == $past(serial_in_pin);
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("received bit lost");

endmodule

// ==== testbench/sspi_peer.sv ====
// far-side serial peripheral: returns a byte while capturing the one sent to it
`timescale 1ns/1ps

module sspi_peer (
	input  wire logic       hclk,
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       ld,
	input  wire logic [7:0] tx,
	output logic            miso,
	output logic      [7:0] rx,
	output int              half
);
	logic [7:0] sh = 8'h0;
	logic       sck_d = 1'b0;
	int         cnt = 0;

	// ==========================================================
	// shifter: idle low, capture on rise, shift on fall
	assign miso = sh[7];
	always @(posedge sck) rx <= {rx[6:0], mosi};
	// spent bits refill with a toggling pattern, not a stale level
	always @(negedge sck or posedge ld) begin
		if (ld)
			sh <= tx;
		else
			sh <= {sh[6:0], ~sh[6]};
	end

	// ==========================================================
	// clock cycles between the last two serial clock edges
	always @(posedge hclk) begin
		sck_d <= sck;
		if (sck !== sck_d) begin
			half <= cnt;
			cnt  <= 1;
		end else
			cnt <= cnt + 1;
	end
endmodule

// ==== testbench/tb_top.sv ====
// testbench: register bus tasks and test sequences for the serial port
`timescale 1ns/1ps
`include "sspi_cfg.svh"

module tb_top;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, tick = 0, ss_n = 1, ld = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0]  htrans = '0;
	logic [7:0]  rx;
	logic        hreadyout, hresp, sck_o, sck_oe, miso, mosi, mosi_oe, irq;
	int          half, n_errors = 0, checks = 0, tcnt = 0;
	logic        ext_sck = 0;
	// the clock pin carries the port's drive while its clock output is enabled, else the bench's
	wire  logic  sck_pin = sck_oe ? sck_o : ext_sck;
	logic [7:0]  ct = `SSPI_IX_PORT_CTRL, bf = `SSPI_IX_DATA_BUF, dc = `SSPI_IX_DIR_C;
	logic [3:0]  md[4] = '{`SSPI_M_DIV4, `SSPI_M_DIV16, `SSPI_M_DIV64, `SSPI_M_TMR};
	int          hp[4] = '{`SSPI_FOSC_DIV4 / 2, `SSPI_FOSC_DIV16 / 2, `SSPI_FOSC_DIV64 / 2, 5};

	always #10 hclk = ~hclk;
	// timer two pulses every fifth cycle
	always @(posedge hclk) begin
		tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
		tick <= (tcnt == 4);
	end

	sspi_top i_sspi_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_two_tick(tick),
		.sck_i(sck_pin), .sck_o(sck_o), .sck_oe(sck_oe), .serial_in_pin(miso),
		.serial_out_pin_o(mosi), .serial_out_pin_oe(mosi_oe), .ss_n_i(ss_n), .irq(irq));
	sspi_peer i_sspi_peer (.hclk(hclk), .sck(sck_pin), .mosi(mosi), .ld(ld), .tx(8'h3c),
		.miso(miso), .rx(rx), .half(half));

	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// entered just after a rising edge; hready gates both phases
	task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {22'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
		xfer(idx, 1'b0, 32'h0);
		chk(rd, e);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ==========================================================
	// sequence
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(dc, 32'hff);
		rdc(ct, 32'h0);
		rdc(8'h50, 32'h0);
		$display("test reset done");
		xfer(dc, 1'b1, 32'hd7);
		xfer(`SSPI_IX_IRQ_ENABLE, 1'b1, 32'h1);
		for (int m = 0; m < 4; m++) begin
			xfer(ct, 1'b1, 32'h0);
			xfer(ct, 1'b1, {24'h0, 4'h2, md[m]});
			ld <= 1'b1;
			@(posedge hclk);
			ld <= 1'b0;
			xfer(bf, 1'b1, 32'ha5);
			for (int k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge hclk);
			chk({31'h0, irq}, 32'h1);
			chk(32'(half), 32'(hp[m]));
			chk({24'h0, rx}, 32'ha5);
			rdc(bf, 32'h3c);
			rdc(`SSPI_IX_IRQ_STATUS, 32'h1);
			rdc(`SSPI_IX_IRQ_FLAGS1, 32'h8);
			// odd modes clear through the clear register, even ones through the flags
			if (m[0])
				xfer(`SSPI_IX_IRQ_CLEAR, 1'b1, 32'h1);
			else
				xfer(`SSPI_IX_IRQ_FLAGS1, 1'b1, 32'h0);
			rdc(`SSPI_IX_IRQ_STATUS, 32'h0);
			chk({31'h0, irq}, 32'h0);
			$display("test mode %0d done", m);
		end
		xfer(ct, 1'b1, 32'h0);
		xfer(ct, 1'b1, 32'h30);
		repeat (3) @(posedge hclk);
		chk({30'h0, sck_oe, sck_o}, 32'h3);
		xfer(ct, 1'b1, 32'h0);
		repeat (3) @(posedge hclk);
		chk({30'h0, sck_oe, mosi_oe}, 32'h0);
		xfer(ct, 1'b1, 32'h26);
		xfer(bf, 1'b1, 32'h5a);
		repeat (100) @(posedge hclk);
		chk({29'h0, sck_oe, mosi_oe, irq}, 32'h0);
		$display("test idle modes done");
		// slave, select ignored: the bench clocks the pin and the peer together
		xfer(ct, 1'b1, 32'h0);
		xfer(dc, 1'b1, 32'hdf);
		xfer(`SSPI_IX_DIR_A, 1'b1, 32'h20);
		rdc(`SSPI_IX_DIR_A, 32'h20);
		xfer(ct, 1'b1, 32'h25);
		ld <= 1'b1;
		@(posedge hclk);
		ld <= 1'b0;
		xfer(bf, 1'b1, 32'h96);
		repeat (16) begin
			repeat (10) @(posedge hclk);
			ext_sck <= ~ext_sck;
		end
		repeat (10) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		chk({24'h0, rx}, 32'h96);
		rdc(bf, 32'h3c);
		xfer(`SSPI_IX_IRQ_CLEAR, 1'b1, 32'h1);
		$display("test slave transfer done");
		xfer(ct, 1'b1, 32'h0);
		xfer(`SSPI_IX_PORT_STATE, 1'b1, 32'h40);
		xfer(ct, 1'b1, 32'h24);
		repeat (6) @(posedge hclk);
		rdc(dc, 32'hff);
		// write back what was read while deselected
		xfer(dc, 1'b1, rd);
		ss_n <= 1'b0;
		repeat (6) @(posedge hclk);
		chk({31'h0, mosi_oe}, 32'h0);
		xfer(dc, 1'b1, 32'hdf);
		repeat (3) @(posedge hclk);
		chk({31'h0, mosi_oe}, 32'h1);
		ss_n <= 1'b1;
		repeat (6) @(posedge hclk);
		chk({31'h0, mosi_oe}, 32'h0);
		$display("test slave select done");
		test_done;
	end

	// the tests need under two thousand cycles; this is ten times more
	initial begin
		#400000;
		n_errors++;
		test_done;
	end
endmodule
